// ==== inc/ctx_pkg.sv ====
// Constants and types for the CAN transmit mailbox status block.
// Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
package ctx_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_TSTAT = 12'h008;
    localparam logic [11:0] OFS_EVT   = 12'h00c;
    localparam logic [11:0] OFS_MASK  = 12'h010;
    localparam logic [31:0] RST_TSTAT = 32'h1c000000;
    localparam logic [31:0] RST_ZERO  = 32'h00000000;

    // Per-mailbox field positions, box b sits at b * BOX_STRIDE
    localparam int BOX_STRIDE = 8;
    localparam int POS_HALT   = 7;
    localparam int POS_FAULT  = 3;
    localparam int POS_ARB    = 2;
    localparam int POS_CLEAN  = 1;
    localparam int POS_DONE   = 0;
    // Shared fields
    localparam int POS_FINAL  = 29;
    localparam int POS_VACANT = 26;
    localparam int POS_NUM    = 24;
    localparam int NUM_BOXES  = 3;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // One-cycle events from the transmit engine, one set per mailbox
    typedef struct packed {
        logic queue;   // Frame loaded, mailbox becomes pending
        logic start;   // Transmission attempt begins
        logic ok;      // Finished without error, mailbox empties
        logic err;     // Finished with error
        logic arb;     // Arbitration lost
        logic drop;    // Frame aborted after halt, mailbox empties
    } ctx_evt_t;
endpackage : ctx_pkg

// ==== hw/ctx_tx_status.sv ====
// Transmit status register of a three-mailbox CAN controller, AXI4-Lite slave.
// Assumes the transmit engine pulses ctx_evt_t events on aclk, one cycle each.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
module ctx_tx_status (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [11:0]         awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    input  wire logic [11:0]         araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    input  wire ctx_pkg::ctx_evt_t [2:0] box_evt,
    output logic [2:0]               halt_request,
    output logic                     irq
);
    import ctx_pkg::*;

    logic        aw_have_r, w_have_r, bvalid_r, rvalid_r;
    logic [11:0] aw_addr_r;
    logic [31:0] w_data_r, rdata_r, wr_bits, tstat;
    logic [3:0]  w_strb_r;
    logic [1:0]  bresp_r, rresp_r, num;
    logic        wr_go, wr_tstat, wr_mask, rd_go;
    logic [2:0]  full_r, halt_r, fault_r, arb_r, clean_r, done_r;
    logic [2:0]  evt_sts_r, mask_r, vacant, final_q, leave, stay, qin, ended;
    logic [1:0]  rank_r [3];
    logic [1:0]  rank_nxt [3];
    logic [1:0]  cnt_full;

    // Handshake outputs; one write and one read in flight at most
    assign awready = !aw_have_r && !bvalid_r;
    assign wready  = !w_have_r && !bvalid_r;
    assign arready = !rvalid_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;
    assign wr_go   = aw_have_r && w_have_r && !bvalid_r;
    assign rd_go   = arvalid && !rvalid_r;
    assign wr_tstat = wr_go && aw_addr_r[11:2] == OFS_TSTAT[11:2];
    assign wr_mask  = wr_go && aw_addr_r[11:2] == OFS_MASK[11:2];

    // Byte enables gate which bits a write can touch
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            wr_bits[8*k +: 8] = w_strb_r[k] ? w_data_r[8*k +: 8] : 8'h00;
        end
    end

    // Address and data may arrive in either order; hold each until both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= awaddr;
            end else if (wr_go) begin
                aw_have_r <= 1'b0;
            end
            if (wvalid && wready) begin
                w_have_r <= 1'b1;
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end else if (wr_go) begin
                w_have_r <= 1'b0;
            end
        end
    end

    // Write response; unmapped offsets answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (wr_tstat || wr_mask ||
                         aw_addr_r[11:2] == OFS_EVT[11:2]) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read data captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= RST_ZERO;
            rresp_r  <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rresp_r  <= RESP_OKAY;
            if (araddr[11:2] == OFS_TSTAT[11:2]) begin
                rdata_r <= tstat;
            end else if (araddr[11:2] == OFS_EVT[11:2]) begin
                rdata_r <= {29'h0, evt_sts_r};
            end else if (araddr[11:2] == OFS_MASK[11:2]) begin
                rdata_r <= {29'h0, mask_r};
            end else begin
                rdata_r <= RST_ZERO;
                rresp_r <= RESP_SLVERR;
            end
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Per-mailbox flags, identical for every box
    for (genvar b = 0; b < NUM_BOXES; b++) begin : g_box
        logic [7:0] wf;
        ctx_evt_t   ev;
        logic       wipe;
        assign ev  = box_evt[b];
        // Reserved bits are never stored, so any value written is ignored
        assign wf  = wr_tstat ? wr_bits[b*BOX_STRIDE +: 8] : 8'h00;
        assign wipe = wf[POS_DONE];
        assign qin[b]   = ev.queue && !full_r[b];
        assign leave[b] = full_r[b] && (ev.ok || ev.drop);
        assign ended[b] = ev.ok || ev.err || ev.drop;

        // Occupancy; a load into a full box is ignored, even when that box leaves in the same cycle
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                full_r[b] <= 1'b0;
            end else begin
                full_r[b] <= qin[b] || (full_r[b] && !leave[b]);
            end
        end

        // Status flags; hardware set always beats a clear
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                halt_r[b]  <= 1'b0;
                fault_r[b] <= 1'b0;
                arb_r[b]   <= 1'b0;
                clean_r[b] <= 1'b0;
                done_r[b]  <= 1'b0;
            end else begin
                // Only a one sets halt; an empty box drops it
                halt_r[b]  <= vacant[b] ? 1'b0 : (halt_r[b] || wf[POS_HALT]);
                fault_r[b] <= ev.err ||
                              (fault_r[b] && !(wf[POS_FAULT] || wipe || ev.start));
                arb_r[b]   <= ev.arb ||
                              (arb_r[b] && !(wf[POS_ARB] || wipe || ev.start));
                clean_r[b] <= ev.ok ||
                              (clean_r[b] && !(wf[POS_CLEAN] || wipe || ev.err));
                done_r[b]  <= ended[b] || (done_r[b] && !wipe);
            end
        end
    end

    assign vacant       = ~full_r;
    assign stay         = full_r & ~leave;
    assign halt_request = halt_r;
    assign cnt_full     = 2'(full_r[0]) + 2'(full_r[1]) + 2'(full_r[2]);

    // Queue position: new frames go behind survivors, leavers close the gap
    always_comb begin
        logic [1:0] pos;
        pos = 2'(stay[0]) + 2'(stay[1]) + 2'(stay[2]);
        for (int i = 0; i < NUM_BOXES; i++) begin
            rank_nxt[i] = rank_r[i];
            if (qin[i]) begin
                rank_nxt[i] = pos;
                pos = pos + 2'd1;
            end else if (stay[i]) begin
                for (int j = 0; j < NUM_BOXES; j++) begin
                    if (leave[j] && rank_r[j] < rank_r[i]) begin
                        rank_nxt[i] = rank_nxt[i] - 2'd1;
                    end
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rank_r <= '{default: 2'd0};
        end else begin
            rank_r <= rank_nxt;
        end
    end

    // Number field and final-in-queue flags
    always_comb begin
        num = 2'd0;
        if (|vacant) begin
            for (int i = NUM_BOXES - 1; i >= 0; i--) begin
                if (vacant[i]) num = 2'(i);
            end
        end else begin
            for (int i = 0; i < NUM_BOXES; i++) begin
                if (rank_r[i] == 2'd2) num = 2'(i);
            end
        end
        for (int i = 0; i < NUM_BOXES; i++) begin
            final_q[i] = full_r[i] && cnt_full >= 2'd2 &&
                         rank_r[i] == cnt_full - 2'd1;
        end
    end

    // Register image; reserved bits read zero
    always_comb begin
        tstat = RST_ZERO;
        tstat[POS_FINAL +: 3]  = final_q;
        tstat[POS_VACANT +: 3] = vacant;
        tstat[POS_NUM +: 2]    = num;
        for (int b = 0; b < NUM_BOXES; b++) begin
            tstat[b*BOX_STRIDE + POS_HALT]  = halt_r[b];
            tstat[b*BOX_STRIDE + POS_FAULT] = fault_r[b];
            tstat[b*BOX_STRIDE + POS_ARB]   = arb_r[b];
            tstat[b*BOX_STRIDE + POS_CLEAN] = clean_r[b];
            tstat[b*BOX_STRIDE + POS_DONE]  = done_r[b];
        end
    end

    // Sticky end-of-transmit events; a read clears, but a new one survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_sts_r <= 3'h0;
            mask_r    <= 3'h0;
        end else begin
            if (rd_go && araddr[11:2] == OFS_EVT[11:2]) begin
                evt_sts_r <= ended;
            end else begin
                evt_sts_r <= evt_sts_r | ended;
            end
            if (wr_mask) mask_r <= wr_bits[2:0];
        end
    end

    assign irq = |(evt_sts_r & mask_r);

    // Checks
    sequence s_err2;
        box_evt[2].err;
    endsequence
    sequence s_end0;
        box_evt[0].ok || box_evt[0].err || box_evt[0].drop;
    endsequence

    property p_fill;
        @(posedge aclk) disable iff (!aresetn)
        box_evt[0].queue && vacant[0] |=> !vacant[0] && tstat[POS_VACANT] == 1'b0;
    endproperty
    a_fill: assert property (p_fill) else $error("box0 not filled");

    property p_reset_img;
        @(posedge aclk) $rose(aresetn) |-> tstat == RST_TSTAT;
    endproperty
    a_reset_img: assert property (p_reset_img) else $error("bad reset image");

    property p_halt_clr;
        @(posedge aclk) disable iff (!aresetn) vacant[2] |=> !halt_request[2];
    endproperty
    a_halt_clr: assert property (p_halt_clr) else $error("halt kept");

    property p_fault;
        @(posedge aclk) disable iff (!aresetn)
        s_err2 ##0 !box_evt[2].ok |=> tstat[19] && !tstat[17] && tstat[16];
    endproperty
    a_fault: assert property (p_fault) else $error("fault not set");

    property p_fault_clr;
        @(posedge aclk) disable iff (!aresetn)
        box_evt[2].start && !box_evt[2].err |=> !fault_r[2];
    endproperty
    a_fault_clr: assert property (p_fault_clr) else $error("fault not cleared");

    property p_arb;
        @(posedge aclk) disable iff (!aresetn) box_evt[1].arb |=> tstat[10];
    endproperty
    a_arb: assert property (p_arb) else $error("arb loss lost");

    property p_clean;
        @(posedge aclk) disable iff (!aresetn)
        box_evt[1].err && !box_evt[1].ok |=> !tstat[9];
    endproperty
    a_clean: assert property (p_clean) else $error("clean not cleared");

    property p_done_irq;
        @(posedge aclk) disable iff (!aresetn)
        s_end0 ##0 mask_r[0] |=> done_r[0] && irq;
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("done or irq missing");

    property p_last;
        @(posedge aclk) disable iff (!aresetn)
        full_r == 3'h7 |-> rank_r[num] == 2'd2 && final_q[num] &&
                           rank_r[0] != rank_r[1] && rank_r[1] != rank_r[2] &&
                           rank_r[0] != rank_r[2];
    endproperty
    a_last: assert property (p_last) else $error("wrong last box");

    property p_bhold;
        @(posedge aclk) disable iff (!aresetn) bvalid && !bready |=> bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
endmodule : ctx_tx_status

// ==== tb/ctx_engine_model.sv ====
// Transmit engine stand-in: replays requested mailbox events.
// Assumes the bench sets req for one cycle right after a rising edge.
`timescale 1ns/100ps
module ctx_engine_model
    import ctx_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [17:0]  req,
    output ctx_evt_t [2:0]    box_evt
);
    // One-cycle pulses, a held req would repeat the event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            box_evt <= '0;
        end else begin
            box_evt <= req;
        end
    end
endmodule : ctx_engine_model

// ==== tb/tb.sv ====
// Self-checking bench for the transmit status block.
// Assumes the design's AXI4-Lite slave timing; ready is sampled mid-cycle.
`timescale 1ns/100ps
module tb;
    import ctx_pkg::*;
    logic        aclk = 0, aresetn = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [2:0]  halt_request;
    logic [17:0] req = '0;
    ctx_evt_t [2:0] box_evt;
    int          fail_count = 0, n_checks = 0, seed = 63113, i, b, k;
    // Reference state: load order queue and per-box flags
    int          q[$];
    logic [2:0]  vac = 3'h7, hlt = 0, flt = 0, arl = 0, cln = 0, dne = 0, evs = 0, msk = 0;
    logic [31:0] d;

    ctx_tx_status ctx_tx_status_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .box_evt(box_evt), .halt_request(halt_request), .irq(irq));
    ctx_engine_model ctx_engine_model_inst (.aclk(aclk), .aresetn(aresetn), .req(req),
        .box_evt(box_evt));

    initial begin
        forever #20 aclk = ~aclk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Ready sampled at the falling edge, where it is settled for the next rise
    task automatic axw(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        logic pa, pw, ta, tw, bv;
        logic [1:0] r;
        int n;
        pa = 1; pw = 1; bv = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (n = 0; n < 50 && !bv; n++) begin
            @(negedge aclk);
            ta = pa && awready; tw = pw && wready; bv = bvalid; r = bresp;
            @(posedge aclk);
            if (ta) begin awvalid <= 0; pa = 0; end
            if (tw) begin wvalid <= 0; pw = 0; end
        end
        bready <= 0;
        if (!bv) begin fail_count++; end_sim(); end
        chk("bresp", er, r);
    endtask : axw

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic pa, ta, rv;
        logic [31:0] v;
        logic [1:0] r;
        int n;
        pa = 1; rv = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (n = 0; n < 50 && !rv; n++) begin
            @(negedge aclk);
            ta = pa && arready; rv = rvalid; v = rdata; r = rresp;
            @(posedge aclk);
            if (ta) begin arvalid <= 0; pa = 0; end
        end
        rready <= 0;
        if (!rv) begin fail_count++; end_sim(); end
        chk("rdata", e, v);
        chk("rresp", er, r);
    endtask : rdchk

    function automatic logic [31:0] tstat_exp();
        logic [31:0] v;
        v = '0;
        if (q.size() >= 2) v[POS_FINAL + q[$]] = 1'b1;
        v[POS_VACANT +: 3] = vac;
        if (vac != 0) v[POS_NUM +: 2] = vac[0] ? 2'd0 : (vac[1] ? 2'd1 : 2'd2);
        else v[POS_NUM +: 2] = 2'(q[$]);
        for (int j = 0; j < 3; j++)
            v[j*BOX_STRIDE +: 8] = {hlt[j], 3'b000, flt[j], arl[j], cln[j], dne[j]};
        return v;
    endfunction : tstat_exp

    // Kind index: 5 queue, 4 start, 3 ok, 2 err, 1 arb, 0 drop
    task automatic apply(input int x, input int y);
        case (y)
            5: if (vac[x]) begin vac[x] = 0; q.push_back(x); end
            4: begin flt[x] = 0; arl[x] = 0; end
            3: begin cln[x] = 1; dne[x] = 1; end
            2: begin flt[x] = 1; cln[x] = 0; dne[x] = 1; end
            1: arl[x] = 1;
            default: dne[x] = 1;
        endcase
        if (y == 3 || y == 2 || y == 0) evs[x] = 1;
        if (y == 3 || y == 0) begin
            vac[x] = 1; hlt[x] = 0;
            foreach (q[j]) if (q[j] == x) begin q.delete(j); break; end
        end
    endtask : apply

    // Lower boxes applied first, matching the rank of simultaneous loads
    task automatic ev(input logic [17:0] v);
        @(posedge aclk);
        req <= v;
        @(posedge aclk);
        req <= '0;
        repeat (2) @(posedge aclk);
        for (int x = 0; x < 3; x++)
            for (int y = 5; y >= 0; y--) if (v[6*x+y]) apply(x, y);
    endtask : ev

    // Strobe s gates which bytes land, in the design and the model alike
    task automatic wr_ts(input logic [31:0] v, input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        wstrb <= s;
        axw(OFS_TSTAT, v, RESP_OKAY);
        wstrb <= 4'hf;
        v = v & m;
        for (int x = 0; x < 3; x++) begin
            if (v[8*x]) begin dne[x] = 0; cln[x] = 0; flt[x] = 0; arl[x] = 0; end
            if (v[8*x+1]) cln[x] = 0;
            if (v[8*x+2]) arl[x] = 0;
            if (v[8*x+3]) flt[x] = 0;
            if (v[8*x+7] && !vac[x]) hlt[x] = 1;
        end
    endtask : wr_ts

    task automatic chk_all();
        rdchk(OFS_TSTAT, tstat_exp(), RESP_OKAY);
        // Look at the flops away from the edge that updates them
        @(negedge aclk);
        chk("halt_request", {29'h0, hlt}, {29'h0, halt_request});
        chk("irq", {31'h0, |(evs & msk)}, {31'h0, irq});
        rdchk(OFS_EVT, {29'h0, evs}, RESP_OKAY);
        evs = 0;
    endtask : chk_all

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        rdchk(OFS_TSTAT, RST_TSTAT, RESP_OKAY);
        rdchk(OFS_MASK, RST_ZERO, RESP_OKAY);
        rdchk(12'h014, RST_ZERO, RESP_SLVERR);
        axw(12'h014, 32'hffffffff, RESP_SLVERR);
        axw(OFS_MASK, 32'h7, RESP_OKAY);
        msk = 3'h7;
        rdchk(OFS_MASK, 32'h7, RESP_OKAY);
        $display("test registers done");
        // One pending box, then two loaded in the same cycle
        ev(18'h1 << 11);
        chk_all();
        ev((18'h1 << 5) | (18'h1 << 17));
        chk_all();
        wr_ts(32'h00000080, 4'hf);
        chk_all();
        ev(18'h1 << 0);
        chk_all();
        $display("test queue done");
        // Random traffic with write-one-to-clear and halt writes mixed in
        for (i = 0; i < 200; i++) begin
            b = ($random(seed) & 32'h7fffffff) % 3;
            k = vac[b] ? 5 : ($random(seed) & 32'h7fffffff) % 5;
            ev(18'h1 << (6*b + k));
            if (i % 3 == 0) begin
                d = $random(seed) & 32'h008f8f8f;
                wr_ts(d, 4'($random(seed)));
            end
            if (i % 17 == 0) begin
                msk = 3'($random(seed));
                axw(OFS_MASK, {29'h0, msk}, RESP_OKAY);
            end
            chk_all();
        end
        $display("test random done");
        end_sim();
    end
endmodule : tb
